// ==== rtl/acmp_pkg.sv ====
// Constants for the analog comparator control block
package acmp_pkg;
    localparam logic [7:0] DATA_OFS_CSR       = 8'h50;
    localparam logic [7:0] IO_REMAP_OFS       = 8'h20;
    localparam logic [7:0] IO_OFS_CSR         = DATA_OFS_CSR - IO_REMAP_OFS;
    localparam logic [7:0] DATA_OFS_CONV_B    = 8'h7B;
    localparam logic [7:0] DATA_OFS_PIN_OFF   = 8'h7F;
    localparam logic [7:0] RESET_BYTE         = 8'h00;
    // Comparator control/status fields
    localparam int CSR_POWER_OFF   = 7;
    localparam int CSR_BANDGAP     = 6;
    localparam int CSR_OUTPUT      = 5;
    localparam int CSR_FLAG        = 4;
    localparam int CSR_IRQ_EN      = 3;
    localparam int CSR_CAPTURE     = 2;
    localparam int CSR_MODE_HI     = 1;
    localparam int CSR_MODE_LO     = 0;
    // Converter control b fields
    localparam int CONVB_MUX_EN    = 6;
    localparam int CONVB_TRIG_HI   = 2;
    localparam int CONVB_TRIG_LO   = 0;
    // Pin input disable fields
    localparam int PIN_POS_OFF     = 0;
    localparam int PIN_NEG_OFF     = 1;
    localparam logic [7:0] CSR_WMASK   = 8'hDF;
    localparam logic [7:0] CONVB_MASK  = 8'h47;
    localparam logic [7:0] PIN_MASK    = 8'h03;

    typedef enum logic [1:0] {
        MODE_TOGGLE   = 2'h0,
        MODE_RESERVED = 2'h1,
        MODE_FALL     = 2'h2,
        MODE_RISE     = 2'h3
    } irq_mode_e;

    typedef enum logic [2:0] {
        TRIG_FREE_RUN  = 3'h0,
        TRIG_COMPARE   = 3'h1,
        TRIG_EXT_INT0  = 3'h2,
        TRIG_T0_CMPA   = 3'h3,
        TRIG_T0_OVF    = 3'h4,
        TRIG_T1_CMPB   = 3'h5,
        TRIG_T1_OVF    = 3'h6,
        TRIG_T1_CAPT   = 3'h7
    } trig_src_e;

    localparam int NUM_TRIG = 8;
endpackage

// ==== rtl/trig_if.sv ====
// Interface carrying trigger sources into the trigger selector
`timescale 1ns/1ps
interface trig_if;
    logic [7:0] flags;
    logic [2:0] source;
    logic       auto_en;
    logic       conv_en;
    logic       busy;
    logic       start;
    modport ctrl (output flags, output source, output auto_en, output conv_en, output busy, input start);
    modport sel  (input flags, input source, input auto_en, input conv_en, input busy, output start);
endinterface

// ==== rtl/trig_select.sv ====
// Auto-trigger source selection and edge detection
`timescale 1ns/1ps
module trig_select (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic ce,
    trig_if.sel       tb
);
    logic sel_q;
    logic sel_d;
    logic start_q;
    logic start_d;
    logic level;

    // Free running presents a constant low level, so choosing it never makes an edge
    always_comb begin
        level = (tb.source == acmp_pkg::TRIG_FREE_RUN) ? 1'b0 : tb.flags[tb.source];
        sel_d = tb.auto_en ? level : 1'b0;
        // Selector change onto a set flag is a rising edge too
        start_d = tb.auto_en && tb.conv_en && level && !sel_q && !tb.busy;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sel_q   <= 1'b0;
            start_q <= 1'b0;
        end else if (ce) begin
            sel_q   <= sel_d;
            start_q <= start_d;
        end
    end

    assign tb.start = start_q;
endmodule // trig_select

// ==== rtl/analog_comparator_control.sv ====
// Analog comparator control, status and converter trigger selection
`timescale 1ns/1ps
// Overview of operation
// - Mux enable, converter off: converter mux negative
// - Mux enable clear: dedicated pin negative
// - Low channel bits pick one of eight
// - Trigger field inert unless auto-trigger enabled
// - Rising edge of chosen flag starts conversion
// - Switching to set flag makes an edge
// - Selecting free running makes no trigger
// - Trigger field decodes to eight sources
// - Edges during a conversion are ignored
// - Power-off bit switches comparator off anytime
// - Bandgap select feeds reference to positive
// - Output status read-only, synchronised two flops
// - Flag set on mode-selected output event
// - Request needs flag, enable, global enable
// - Flag clears on vector or writing one
// - Capture route feeds output to timer
// - Mode field: toggle, reserved, fall, rise
// - Pin input disable forces port bit zero
// - Control register at data and I/O offsets
module analog_comparator_control (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       ce,
    // Processor register bus
    input  wire logic [7:0] data_addr,
    input  wire logic       data_wr,
    input  wire logic       data_rd,
    input  wire logic [5:0] io_addr,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata,
    // Converter and core context
    input  wire logic       converter_enable,
    input  wire logic       auto_trigger_enable,
    input  wire logic [2:0] channel_select,
    input  wire logic       conversion_busy,
    input  wire logic       conversion_done_flag,
    input  wire logic       ext_int0_flag,
    input  wire logic       t0_cmpa_flag,
    input  wire logic       t0_ovf_flag,
    input  wire logic       t1_cmpb_flag,
    input  wire logic       t1_ovf_flag,
    input  wire logic       t1_capt_flag,
    input  wire logic       global_irq_enable,
    input  wire logic       irq_vector_taken,
    // Analog front end
    input  wire logic       cmp_raw,
    input  wire logic       pos_cmp_pin_in,
    input  wire logic       neg_cmp_pin_in,
    // Outputs
    output logic            conv_auto_start,
    output logic            cmp_irq_req,
    output logic            cmp_power_off,
    output logic            cmp_bandgap_select,
    output logic            neg_src_mux,
    output logic      [2:0] neg_mux_channel,
    output logic            capture_input,
    output logic            pos_pin_buf_en,
    output logic            neg_pin_buf_en,
    output logic            pos_port_bit,
    output logic            neg_port_bit
);
    // ==========================================================
    // Registers
    logic [7:0] csr_q;
    logic [7:0] csr_d;
    logic [7:0] convb_q;
    logic [7:0] convb_d;
    logic [7:0] pin_q;
    logic [7:0] pin_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       sync1_q;
    logic       sync2_q;
    logic       prev_q;
    logic       pos_s1_q;
    logic       pos_s2_q;
    logic       neg_s1_q;
    logic       neg_s2_q;
    logic       pos_port_q;
    logic       neg_port_q;
    logic       cap_q;
    logic       neg_mux_q;
    logic [2:0] chan_q;

    logic       csr_hit_wr;
    logic       csr_hit_rd;
    logic       convb_wr;
    logic       pin_wr;
    logic       event_hit;
    logic       flag_clr;
    logic [7:0] csr_view;

    trig_if tsel();

    // ==========================================================
    // Address decode
    always_comb begin
        csr_hit_wr = (data_wr && data_addr == acmp_pkg::DATA_OFS_CSR) ||
                     (io_wr && {2'h0, io_addr} == acmp_pkg::IO_OFS_CSR);
        csr_hit_rd = (data_rd && data_addr == acmp_pkg::DATA_OFS_CSR) ||
                     (io_rd && {2'h0, io_addr} == acmp_pkg::IO_OFS_CSR);
        convb_wr   = data_wr && data_addr == acmp_pkg::DATA_OFS_CONV_B;
        pin_wr     = data_wr && data_addr == acmp_pkg::DATA_OFS_PIN_OFF;
    end

    // ==========================================================
    // Comparator event detection
    // Powered-off comparator holds its output low; software masks the irq around this
    always_comb begin
        case (acmp_pkg::irq_mode_e'(csr_q[acmp_pkg::CSR_MODE_HI:acmp_pkg::CSR_MODE_LO]))
            acmp_pkg::MODE_TOGGLE: event_hit = sync2_q != prev_q;
            acmp_pkg::MODE_FALL:   event_hit = prev_q && !sync2_q;
            acmp_pkg::MODE_RISE:   event_hit = !prev_q && sync2_q;
            default:               event_hit = 1'b0;
        endcase
    end

    // ==========================================================
    // Register next state
    always_comb begin
        csr_d    = csr_q;
        convb_d  = convb_q;
        pin_d    = pin_q;
        flag_clr = irq_vector_taken ||
                   (csr_hit_wr && wdata[acmp_pkg::CSR_FLAG]);
        if (csr_hit_wr) begin
            csr_d = (wdata & acmp_pkg::CSR_WMASK & ~(8'h01 << acmp_pkg::CSR_FLAG)) |
                    (csr_q & (8'h01 << acmp_pkg::CSR_FLAG));
        end
        if (flag_clr) begin
            csr_d[acmp_pkg::CSR_FLAG] = 1'b0;
        end
        // An event in the clearing cycle still sets the flag
        if (event_hit) begin
            csr_d[acmp_pkg::CSR_FLAG] = 1'b1;
        end
        csr_d[acmp_pkg::CSR_OUTPUT] = 1'b0;
        if (convb_wr) begin
            convb_d = wdata & acmp_pkg::CONVB_MASK;
        end
        if (pin_wr) begin
            pin_d = wdata & acmp_pkg::PIN_MASK;
        end
    end

    // ==========================================================
    // Read data
    always_comb begin
        csr_view = csr_q;
        csr_view[acmp_pkg::CSR_OUTPUT] = sync2_q;
        rdata_d  = acmp_pkg::RESET_BYTE;
        if (csr_hit_rd) begin
            rdata_d = csr_view;
        end else if (data_rd && data_addr == acmp_pkg::DATA_OFS_CONV_B) begin
            rdata_d = convb_q;
        end else if (data_rd && data_addr == acmp_pkg::DATA_OFS_PIN_OFF) begin
            rdata_d = pin_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            csr_q   <= acmp_pkg::RESET_BYTE;
            convb_q <= acmp_pkg::RESET_BYTE;
            pin_q   <= acmp_pkg::RESET_BYTE;
            rdata_q <= acmp_pkg::RESET_BYTE;
        end else if (ce) begin
            csr_q   <= csr_d;
            convb_q <= convb_d;
            pin_q   <= pin_d;
            rdata_q <= rdata_d;
        end
    end

    // ==========================================================
    // Synchronisers and pin path
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync1_q    <= 1'b0;
            sync2_q    <= 1'b0;
            prev_q     <= 1'b0;
            pos_s1_q   <= 1'b0;
            pos_s2_q   <= 1'b0;
            neg_s1_q   <= 1'b0;
            neg_s2_q   <= 1'b0;
            pos_port_q <= 1'b0;
            neg_port_q <= 1'b0;
            cap_q      <= 1'b0;
            neg_mux_q  <= 1'b0;
            chan_q     <= 3'h0;
        end else if (ce) begin
            sync1_q    <= cmp_raw;
            sync2_q    <= sync1_q;
            prev_q     <= sync2_q;
            pos_s1_q   <= pos_cmp_pin_in;
            pos_s2_q   <= pos_s1_q;
            neg_s1_q   <= neg_cmp_pin_in;
            neg_s2_q   <= neg_s1_q;
            pos_port_q <= pos_s2_q && !pin_q[acmp_pkg::PIN_POS_OFF];
            neg_port_q <= neg_s2_q && !pin_q[acmp_pkg::PIN_NEG_OFF];
            cap_q      <= sync2_q && csr_q[acmp_pkg::CSR_CAPTURE];
            neg_mux_q  <= convb_q[acmp_pkg::CONVB_MUX_EN] && !converter_enable;
            chan_q     <= channel_select;
        end
    end

    // ==========================================================
    // Converter trigger selection
    assign tsel.flags   = {t1_capt_flag, t1_ovf_flag, t1_cmpb_flag, t0_ovf_flag,
                           t0_cmpa_flag, ext_int0_flag, csr_q[acmp_pkg::CSR_FLAG], conversion_done_flag};
    assign tsel.source  = convb_q[acmp_pkg::CONVB_TRIG_HI:acmp_pkg::CONVB_TRIG_LO];
    assign tsel.auto_en = auto_trigger_enable;
    assign tsel.conv_en = converter_enable;
    assign tsel.busy    = conversion_busy;

    trig_select u_trig (
        .mclk (mclk),
        .rst  (rst),
        .ce   (ce),
        .tb   (tsel.sel)
    );

    // ==========================================================
    // Outputs
    assign rdata              = rdata_q;
    assign conv_auto_start    = tsel.start;
    assign cmp_irq_req        = csr_q[acmp_pkg::CSR_FLAG] && csr_q[acmp_pkg::CSR_IRQ_EN] && global_irq_enable;
    assign cmp_power_off      = csr_q[acmp_pkg::CSR_POWER_OFF];
    assign cmp_bandgap_select = csr_q[acmp_pkg::CSR_BANDGAP];
    assign neg_src_mux        = neg_mux_q;
    assign neg_mux_channel    = chan_q;
    assign capture_input      = cap_q;
    assign pos_pin_buf_en     = !pin_q[acmp_pkg::PIN_POS_OFF];
    assign neg_pin_buf_en     = !pin_q[acmp_pkg::PIN_NEG_OFF];
    assign pos_port_bit       = pos_port_q;
    assign neg_port_bit       = neg_port_q;
endmodule // analog_comparator_control

// ==== test/acmp_chk.sv ====
// Concurrent checks on the analog comparator control ports
`timescale 1ns/1ps
module acmp_chk (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       ce,
    input wire logic [7:0] data_addr,
    input wire logic       data_wr,
    input wire logic       data_rd,
    input wire logic       io_rd,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       global_irq_enable,
    input wire logic       auto_trigger_enable,
    input wire logic       converter_enable,
    input wire logic       conversion_busy,
    input wire logic       conv_auto_start,
    input wire logic       cmp_irq_req,
    input wire logic       cmp_power_off,
    input wire logic       cmp_bandgap_select,
    input wire logic       pos_pin_buf_en
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ==========================================
    // Register bus
    a_power_write: assert property ($past(ce && data_wr && data_addr == 8'h50)
        |-> cmp_power_off == $past(wdata[7])) else $error("power bit not written");
    a_bandgap_write: assert property ($past(ce && data_wr && data_addr == 8'h50)
        |-> cmp_bandgap_select == $past(wdata[6])) else $error("bandgap bit not written");
    a_pin_write: assert property ($past(ce && data_wr && data_addr == 8'h7F)
        |-> pos_pin_buf_en == !$past(wdata[0])) else $error("pin buffer enable wrong");
    a_unmapped_zero: assert property ($past(ce && data_rd && !io_rd && !(data_addr inside {8'h50, 8'h7B, 8'h7F}))
        |-> rdata == 8'h00) else $error("unmapped read not zero");
    a_reserved_zero: assert property ($past(ce && data_rd && !io_rd && data_addr == 8'h7B)
        |-> (rdata & 8'hB8) == 8'h00) else $error("reserved bits not zero");
    // ==========================================
    // Interrupt and trigger
    a_irq_gate: assert property (cmp_irq_req |-> global_irq_enable)
        else $error("irq request without global enable");
    a_start_gate: assert property (conv_auto_start
        |-> $past(auto_trigger_enable && converter_enable && !conversion_busy)) else $error("start not allowed");
    a_start_pulse: assert property (conv_auto_start |=> !conv_auto_start)
        else $error("start longer than one cycle");
    c_start: cover property (conv_auto_start);
    c_irq: cover property (cmp_irq_req);
    c_unmapped: cover property (data_rd && data_addr == 8'h40);
endmodule // acmp_chk

bind analog_comparator_control acmp_chk u_chk (.mclk, .rst, .ce, .data_addr, .data_wr, .data_rd, .io_rd, .wdata,
    .rdata, .global_irq_enable, .auto_trigger_enable, .converter_enable, .conversion_busy, .conv_auto_start,
    .cmp_irq_req, .cmp_power_off, .cmp_bandgap_select, .pos_pin_buf_en);

// ==== test/test_analog_comparator_control.sv ====
// Self-checking bench for the analog comparator control block
`timescale 1ns/1ps
module test_analog_comparator_control;
    logic mclk, rst, ce, data_wr, data_rd, io_wr, io_rd, converter_enable, auto_trigger_enable;
    logic conversion_busy, conversion_done_flag, global_irq_enable, irq_vector_taken, cmp_raw;
    logic pos_cmp_pin_in, neg_cmp_pin_in, conv_auto_start, cmp_irq_req, cmp_power_off, cmp_bandgap_select;
    logic neg_src_mux, capture_input, pos_pin_buf_en, neg_pin_buf_en, pos_port_bit, neg_port_bit;
    logic [7:0] data_addr, wdata, rdata, tf;
    logic [5:0] io_addr;
    logic [2:0] channel_select, neg_mux_channel;
    int         n_errors, total_checks, n;
    // Address, write data, expected read back
    logic [7:0] rows [7][3] = '{'{8'h50, 8'hF7, 8'hC7}, '{8'h7B, 8'hFF, 8'h47}, '{8'h7F, 8'hFF, 8'h03},
        '{8'h50, 8'h00, 8'h00}, '{8'h7B, 8'h00, 8'h00}, '{8'h7F, 8'h00, 8'h00}, '{8'h40, 8'hFF, 8'h00}};

    analog_comparator_control dut (.mclk, .rst, .ce, .data_addr, .data_wr, .data_rd, .io_addr, .io_wr, .io_rd,
        .wdata, .rdata, .converter_enable, .auto_trigger_enable, .channel_select, .conversion_busy,
        .conversion_done_flag, .ext_int0_flag(tf[2]), .t0_cmpa_flag(tf[3]), .t0_ovf_flag(tf[4]),
        .t1_cmpb_flag(tf[5]), .t1_ovf_flag(tf[6]), .t1_capt_flag(tf[7]), .global_irq_enable, .irq_vector_taken,
        .cmp_raw, .pos_cmp_pin_in, .neg_cmp_pin_in, .conv_auto_start, .cmp_irq_req, .cmp_power_off,
        .cmp_bandgap_select, .neg_src_mux, .neg_mux_channel, .capture_input, .pos_pin_buf_en, .neg_pin_buf_en,
        .pos_port_bit, .neg_port_bit);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ==========================================
    // Tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask

    task automatic w(input int k);
        repeat (k) @(negedge mclk);
    endtask

    // Idle cycle first, so back-to-back calls never re-raise a strobe in the step that lowered it
    task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] d);
        w(1);
        data_addr = a;
        io_addr = a[5:0];
        wdata = d;
        {data_wr, io_wr} = {!io, io};
        w(1);
        {data_wr, io_wr} = 2'b00;
    endtask

    task automatic rd(input logic io, input logic [7:0] a, input logic [7:0] exp);
        w(1);
        data_addr = a;
        io_addr = a[5:0];
        {data_rd, io_rd} = {!io, io};
        w(1);
        {data_rd, io_rd} = 2'b00;
        chk(rdata, exp);
    endtask

    // Six cycles cover the two-flop sync, the flag and the registered start
    task automatic cnt(input int exp);
        n = 0;
        repeat (6) begin
            w(1);
            n += int'(conv_auto_start);
        end
        chk(8'(n), 8'(exp));
    endtask

    task automatic stop_test;
        if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        ce = 1'b1;
        rst = 1'b1;
        {data_wr, data_rd, io_wr, io_rd, converter_enable, auto_trigger_enable, conversion_busy} = '0;
        {conversion_done_flag, global_irq_enable, irq_vector_taken, cmp_raw, pos_cmp_pin_in, neg_cmp_pin_in} = '0;
        {data_addr, wdata, tf, io_addr, channel_select} = '0;
        repeat (5) @(posedge mclk);
        w(1);
        rst = 1'b0;
        for (int i = 0; i < 3; i++) rd(0, rows[i][0], 8'h00);
        for (int i = 0; i < 7; i++) begin
            wr(0, rows[i][0], rows[i][1]);
            rd(0, rows[i][0], rows[i][2]);
        end
        wr(1, 8'h30, 8'h0A);
        rd(1, 8'h30, 8'h0A);
        rd(0, 8'h50, 8'h0A);
        wr(0, 8'h50, 8'h02);
        wr(0, 8'h50, 8'hC0);
        chk({6'h00, cmp_power_off, cmp_bandgap_select}, 8'h03);
        channel_select = 3'h5;
        wr(0, 8'h7B, 8'h40);
        w(2);
        chk({4'h0, neg_src_mux, neg_mux_channel}, 8'h0D);
        converter_enable = 1'b1;
        w(2);
        chk({7'h00, neg_src_mux}, 8'h00);
        converter_enable = 1'b0;
        wr(0, 8'h7B, 8'h00);
        w(2);
        chk({7'h00, neg_src_mux}, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr(0, 8'h50, 8'h10 | 8'(m));
            cmp_raw = 1'b1;
            w(4);
            rd(0, 8'h50, 8'h20 | 8'(m) | ((m == 0 || m == 3) ? 8'h10 : 8'h00));
            wr(0, 8'h50, 8'h10 | 8'(m));
            cmp_raw = 1'b0;
            w(4);
            rd(0, 8'h50, 8'(m) | ((m == 0 || m == 2) ? 8'h10 : 8'h00));
        end
        wr(0, 8'h50, 8'h1B);
        global_irq_enable = 1'b1;
        cmp_raw = 1'b1;
        w(4);
        chk({7'h00, cmp_irq_req}, 8'h01);
        global_irq_enable = 1'b0;
        w(1);
        chk({7'h00, cmp_irq_req}, 8'h00);
        global_irq_enable = 1'b1;
        irq_vector_taken = 1'b1;
        w(1);
        irq_vector_taken = 1'b0;
        w(1);
        chk({7'h00, cmp_irq_req}, 8'h00);
        wr(0, 8'h50, 8'h03);
        wr(0, 8'h50, 8'h04);
        w(3);
        chk({7'h00, capture_input}, 8'h01);
        wr(0, 8'h50, 8'h00);
        w(3);
        chk({7'h00, capture_input}, 8'h00);
        {pos_cmp_pin_in, neg_cmp_pin_in} = 2'b11;
        wr(0, 8'h7F, 8'h03);
        w(3);
        chk({4'h0, pos_pin_buf_en, neg_pin_buf_en, pos_port_bit, neg_port_bit}, 8'h00);
        wr(0, 8'h7F, 8'h00);
        w(3);
        chk({4'h0, pos_pin_buf_en, neg_pin_buf_en, pos_port_bit, neg_port_bit}, 8'h0F);
        {auto_trigger_enable, converter_enable} = 2'b11;
        for (int s = 2; s < 8; s++) begin
            wr(0, 8'h7B, 8'(s));
            tf[s] = 1'b1;
            cnt(1);
            tf[s] = 1'b0;
        end
        tf[3] = 1'b1;
        wr(0, 8'h7B, 8'h02);
        wr(0, 8'h7B, 8'h03);
        cnt(1);
        tf[3] = 1'b0;
        w(1);
        conversion_busy = 1'b1;
        tf[3] = 1'b1;
        cnt(0);
        conversion_busy = 1'b0;
        cnt(0);
        tf[3] = 1'b0;
        auto_trigger_enable = 1'b0;
        w(1);
        tf[3] = 1'b1;
        cnt(0);
        tf[3] = 1'b0;
        auto_trigger_enable = 1'b1;
        conversion_done_flag = 1'b1;
        wr(0, 8'h7B, 8'h00);
        cnt(0);
        wr(0, 8'h50, 8'h13);
        cmp_raw = 1'b0;
        w(3);
        wr(0, 8'h7B, 8'h01);
        cmp_raw = 1'b1;
        cnt(1);
        // A write while the clock enable is low must leave the register untouched
        ce = 1'b0;
        wr(0, 8'h7F, 8'h03);
        ce = 1'b1;
        rd(0, 8'h7F, 8'h00);
        stop_test();
    end
endmodule // test_analog_comparator_control
